// ---- rtl/seq_pkg.sv ----
// Shared constants and types of the conversion sequencer.
// Assumes one 25 MHz clock and an APB master with 32-bit data.
package seq_pkg;

    // Clock and conversion timing
    localparam int unsigned CLK_NS   = 40;
    localparam int unsigned CONV_NS  = 500;
    localparam int unsigned CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TMR_W    = 5;

    // Stack geometry
    localparam int unsigned STEPS = 32;
    localparam int unsigned PTR_W = 5;

    // Register indices; byte address is four times the index
    localparam logic [5:0] CFG_IDX   = 6'h02;
    localparam logic [5:0] CHAN_IDX  = 6'h03;
    localparam logic [5:0] STAT_IDX  = 6'h11;
    localparam logic [5:0] STACK_IDX = 6'h20;
    localparam int unsigned IDX_LSB  = 2;
    localparam int unsigned IDX_MSB  = 7;

    // Field positions
    localparam int unsigned CFG_SEQ_BIT   = 5;
    localparam int unsigned CFG_BURST_BIT = 6;
    localparam int unsigned STK_LAST_BIT  = 8;
    localparam int unsigned REG_W         = 9;

    // Reset values
    localparam logic [8:0]  CFG_RST   = 9'h000;
    localparam logic [8:0]  CHAN_RST  = 9'h000;
    localparam logic [8:0]  STACK_RST = 9'h000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic [3:0] b;
        logic [3:0] a;
    } pair_t;

    localparam pair_t PAIR_ZERO = 8'h00;

    typedef struct packed {
        logic       sw_mode;
        logic       seq_en;
        logic       burst;
        logic [2:0] range;
    } strap_t;

    localparam strap_t STRAP_RST = 6'h00;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } seq_state_t;

endpackage : seq_pkg

// ---- rtl/rise_detect.sv ----
// Rising edge detector for a level already in the pclk domain.
// Assumes the input is synchronous to pclk.
`timescale 1ns/100ps
module rise_detect (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Level in, pulse out
    input  wire logic level,
    output logic      rise
);
    logic prev_q;

    // Previous level starts low; an edge seen on the first edge after release
    // falls in the strap capture cycle, where the sequencer refuses starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
endmodule : rise_detect

// ---- rtl/cycle_timer.sv ----
// Down counter that marks the last cycle of a fixed interval.
// Assumes start is a one-cycle pulse; a new start reloads.
`timescale 1ns/100ps
module cycle_timer #(
    parameter int unsigned W     = 5,
    parameter int unsigned COUNT = 13
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic start,
    input  wire logic abort,
    output logic      done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Reload on start, count toward one, stop at zero
    assign cnt_d = abort ? '0 :
                   start ? W'(COUNT) :
                   (cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
    assign done  = (cnt_q == W'(1)) & ~abort;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : cycle_timer

// ---- rtl/adc_channel_sequencer.sv ----
// Conversion sequencer: picks the channel pair of each conversion.
// Assumes synchronous pins, an APB master, and a converter that takes
// conv_launch with conv_pair and needs a fixed conversion time.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module adc_channel_sequencer (
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Straps and configuration pins
    input  wire logic            sw_mode_strap,
    input  wire logic            sequence_enable,
    input  wire logic            burst_enable,
    input  wire logic [2:0]      channel_range_select,
    // Conversion control
    input  wire logic            conversion_start,
    input  wire logic            partial_reset,
    output logic                 busy,
    output logic                 conv_launch,
    output seq_pkg::pair_t       conv_pair,
    // Result readback order
    input  wire logic            result_read,
    output seq_pkg::pair_t       result_pair,
    output logic [5:0]           result_count
);

    logic                        taken_q;
    seq_pkg::strap_t             strap_q;
    logic [2:0]                  range_q;
    logic [seq_pkg::REG_W-1:0]   cfg_q;
    logic [seq_pkg::REG_W-1:0]   chan_q;
    logic [seq_pkg::REG_W-1:0]   stack_q [seq_pkg::STEPS];
    seq_pkg::seq_state_t         state_q;
    seq_pkg::seq_state_t         state_d;
    logic [seq_pkg::PTR_W-1:0]   ptr_q;
    logic [seq_pkg::PTR_W-1:0]   ptr_d;
    logic [seq_pkg::PTR_W-1:0]   rptr_q;
    logic [5:0]                  len_q;
    logic                        launch_q;
    seq_pkg::pair_t              pair_q;
    seq_pkg::pair_t              rpair_q;

    // Bus decode
    wire                         access   = psel & penable;
    wire  [5:0]                  idx      = paddr[seq_pkg::IDX_MSB:seq_pkg::IDX_LSB];
    wire                         hit_cfg  = (idx == seq_pkg::CFG_IDX);
    wire                         hit_chan = (idx == seq_pkg::CHAN_IDX);
    wire                         hit_stat = (idx == seq_pkg::STAT_IDX);
    wire                         hit_stk  = (idx >= seq_pkg::STACK_IDX);
    wire  [seq_pkg::PTR_W-1:0]   stk_sel  = idx[seq_pkg::PTR_W-1:0];
    wire                         mapped   = hit_cfg | hit_chan | hit_stat | hit_stk;
    wire                         wr_en    = access & pwrite & mapped;
    wire                         part_rst = partial_reset;

    // Effective mode: hardware from straps, software from the config register
    wire                         sw       = strap_q.sw_mode;
    wire                         sw_seq   = cfg_q[seq_pkg::CFG_SEQ_BIT];
    wire                         sw_burst = sw_seq & cfg_q[seq_pkg::CFG_BURST_BIT];
    wire                         seq_on   = sw ? sw_seq : strap_q.seq_en;
    wire                         burst_on = sw ? sw_burst : (strap_q.seq_en & strap_q.burst);

    // Pair for a given step
    function automatic seq_pkg::pair_t step_pair(input logic [seq_pkg::PTR_W-1:0] p);
        seq_pkg::pair_t r;
        r = seq_pkg::PAIR_ZERO;
        if (!seq_on) begin
            r = sw ? seq_pkg::pair_t'(chan_q[7:0]) : seq_pkg::PAIR_ZERO;
        end else if (sw) begin
            r = seq_pkg::pair_t'(stack_q[p][7:0]);
        end else begin
            r.a = 4'(p);
            r.b = 4'(p);
        end
        return r;
    endfunction : step_pair

    // Last step of the sequence in either mode
    // last-step flag or top of stack
    wire                         sw_last  = stack_q[ptr_q][seq_pkg::STK_LAST_BIT] |
                                            (ptr_q == seq_pkg::PTR_W'(seq_pkg::STEPS - 1));
    // range n ends at pair n
    wire                         hw_last  = (ptr_q == seq_pkg::PTR_W'(range_q));
    wire                         is_last  = ~seq_on | (sw ? sw_last : hw_last);

    // Conversion start handling
    logic                        start_rise;
    logic                        tmr_done;
    wire                         start_acc = start_rise & (state_q == seq_pkg::ST_IDLE) & taken_q & ~part_rst;
    wire                         step_done = (state_q == seq_pkg::ST_CONV) & tmr_done & ~part_rst;
    wire                         relaunch  = step_done & burst_on & ~is_last;
    wire                         go        = start_acc | relaunch;

    rise_detect u_start_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .level   (conversion_start),
        .rise    (start_rise)
    );

    cycle_timer #(
        .W     (seq_pkg::TMR_W),
        .COUNT (seq_pkg::CONV_CYC)
    ) u_conv_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (go),
        .abort   (part_rst),
        .done    (tmr_done)
    );

    // Next state and pointer
    always_comb begin
        state_d = state_q;
        ptr_d   = ptr_q;
        case (state_q)
            seq_pkg::ST_IDLE: begin
                if (start_acc) begin
                    state_d = seq_pkg::ST_CONV;
                end
            end
            seq_pkg::ST_CONV: begin
                if (step_done) begin
                    ptr_d   = is_last ? '0 : ptr_q + seq_pkg::PTR_W'(1);
                    state_d = relaunch ? seq_pkg::ST_CONV : seq_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = seq_pkg::ST_IDLE;
            end
        endcase
        if (part_rst) begin
            state_d = seq_pkg::ST_IDLE;
            ptr_d   = '0;
        end
    end

    // Sequencer state; pair chosen from the pointer that the step will use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= seq_pkg::ST_IDLE;
            ptr_q    <= '0;
            launch_q <= 1'b0;
            pair_q   <= seq_pkg::PAIR_ZERO;
        end else begin
            state_q  <= state_d;
            ptr_q    <= ptr_d;
            launch_q <= go;
            if (go) begin
                pair_q <= step_pair(relaunch ? ptr_d : ptr_q);
            end
        end
    end

    // Straps caught once on the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_q <= 1'b0;
            strap_q <= seq_pkg::STRAP_RST;
        end else if (!taken_q) begin
            taken_q <= 1'b1;
            strap_q <= '{sw_mode: sw_mode_strap, seq_en: sequence_enable,
                         burst: burst_enable, range: channel_range_select};
        end
    end

    // Range pins retaken at the end of a plain sequence or the start of a burst;
    // the enable and burst straps are never retaken
    wire range_upd = (step_done & is_last & ~burst_on) | (start_acc & burst_on);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_q <= '0;
        end else if (!taken_q) begin
            range_q <= channel_range_select;
        end else if (range_upd & ~sw) begin
            range_q <= channel_range_select;
        end
    end

    // Software registers; partial reset leaves them alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q  <= seq_pkg::CFG_RST;
            chan_q <= seq_pkg::CHAN_RST;
        end else begin
            if (wr_en & hit_cfg) begin
                cfg_q <= pwdata[seq_pkg::REG_W-1:0];
            end
            if (wr_en & hit_chan) begin
                chan_q <= pwdata[seq_pkg::REG_W-1:0];
            end
        end
    end

    for (genvar g = 0; g < seq_pkg::STEPS; g++) begin : g_stack
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stack_q[g] <= seq_pkg::STACK_RST;
            end else if (wr_en & hit_stk & (stk_sel == seq_pkg::PTR_W'(g))) begin
                stack_q[g] <= pwdata[seq_pkg::REG_W-1:0];
            end
        end
    end

    // Readback order follows the converted order; a new sequence restarts it
    wire seq_begin = start_acc & (ptr_q == '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rptr_q  <= '0;
            len_q   <= '0;
            rpair_q <= seq_pkg::PAIR_ZERO;
        end else begin
            if (seq_begin | part_rst) begin
                rptr_q <= '0;
                len_q  <= '0;
            end else begin
                if (step_done) begin
                    len_q <= len_q + 6'h01;
                end
                if (result_read & (len_q != '0)) begin
                    rptr_q <= rptr_q + seq_pkg::PTR_W'(1);
                    len_q  <= len_q - (step_done ? 6'h00 : 6'h01);
                end
            end
            rpair_q <= step_pair(rptr_q);
        end
    end

    // Status word: pointer, state, effective mode bits
    wire [31:0] stat_word = {16'h0000, len_q, burst_on, seq_on, sw, busy, 1'b0, ptr_q};

    // Read mux and answer; one-cycle access, unmapped gives an error
    assign prdata  = !access   ? seq_pkg::DATA_ZERO :
                     hit_cfg   ? {23'h000000, cfg_q} :
                     hit_chan  ? {23'h000000, chan_q} :
                     hit_stat  ? stat_word :
                     hit_stk   ? {23'h000000, stack_q[stk_sel]} : seq_pkg::DATA_ZERO;
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // busy spans every step of a burst
    assign busy         = (state_q != seq_pkg::ST_IDLE);
    assign conv_launch  = launch_q;
    assign conv_pair    = pair_q;
    assign result_pair  = rpair_q;
    assign result_count = len_q;

    // a start edge seen while busy launches nothing
    launch_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_rise && busy && !relaunch |=> !launch_q)
        else $error("start accepted while busy");

    // hardware sequence opens on pair zero
    hw_first_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_acc && !sw && ptr_q == '0 |=> pair_q == seq_pkg::PAIR_ZERO)
        else $error("hardware sequence did not open on pair zero");

    strap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        taken_q && $past(taken_q) |-> $stable(strap_q))
        else $error("strap configuration changed after release");

    ptr_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        step_done && is_last |=> ptr_q == '0 && !busy)
        else $error("pointer did not wrap after last step");

    ptr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        step_done && !is_last && !burst_on ##1 !part_rst |-> ptr_q == $past(ptr_q) + seq_pkg::PTR_W'(1))
        else $error("pointer did not advance by one");

    burst_cont_a: assert property (@(posedge pclk) disable iff (!presetn)
        step_done && burst_on && !is_last |=> busy && launch_q)
        else $error("burst stopped before the last step");

    partial_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        part_rst |=> ptr_q == '0 && cfg_q == $past(cfg_q) && !busy)
        else $error("partial reset disturbed registers or pointer");

    // busy holds for the first eight cycles of a conversion
    busy_span_a: assert property (@(posedge pclk) disable iff (!presetn || part_rst)
        start_acc |=> busy [*8])
        else $error("busy fell early");

    // software step fields reach the converter
    sw_fields_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_acc && sw && seq_on |=> pair_q == seq_pkg::pair_t'($past(stack_q[ptr_q][7:0])))
        else $error("wrong channel pair launched");

endmodule : adc_channel_sequencer

// ---- dv/host_model.sv ----
// Host controller model: pulses conversion start and reads results back.
// Assumes the bench calls its tasks and all pins are pclk synchronous.
`timescale 1ns/100ps
module host_model (
    // Clock
    input  wire logic            pclk,
    // From the sequencer
    input  wire logic            busy,
    input  wire seq_pkg::pair_t  result_pair,
    // To the sequencer and the result port
    output logic                 conversion_start,
    output logic                 result_read,
    output logic                 frame_n
);
    // Idle levels from time zero
    initial begin
        conversion_start = 1'b0;
        result_read      = 1'b0;
        frame_n          = 1'b1;
    end

    // Start held for two edges so that a single rising edge is seen
    task start_conv();
        @(posedge pclk);
        conversion_start <= 1'b1;
        @(posedge pclk);
        @(posedge pclk);
        conversion_start <= 1'b0;
    endtask : start_conv

    // wait for busy low
    // Unbounded on purpose; the bench watchdog ends a stuck busy
    task wait_idle();
        do begin
            @(posedge pclk);
        end while (busy !== 1'b0);
    endtask : wait_idle

    // one frame for all results
    // Two edges first: result_pair lags the read pointer by one cycle
    task read_one(output logic [7:0] pair);
        @(posedge pclk);
        @(posedge pclk);
        pair = result_pair;
        frame_n     <= 1'b0;
        result_read <= 1'b1;
        @(posedge pclk);
        result_read <= 1'b0;
    endtask : read_one

    // Frame closes only after the last result
    task close_frame();
        @(posedge pclk);
        frame_n <= 1'b1;
    endtask : close_frame
endmodule : host_model

// ---- dv/test_adc_channel_sequencer.sv ----
// Self-checking bench of the conversion sequencer, hardware and software modes.
// Assumes the host model drives start and reads; the bench is the APB master.
`timescale 1ns/100ps
module test_adc_channel_sequencer;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]     paddr;
    logic [31:0]    pwdata, prdata;
    logic           sw_mode_strap, sequence_enable, burst_enable, partial_reset;
    logic [2:0]     channel_range_select;
    logic           conversion_start, busy, conv_launch, result_read, frame_n;
    seq_pkg::pair_t conv_pair, result_pair;
    logic [5:0]     result_count;
    int             error_cnt, checks, busy_cyc;
    logic [7:0]     got_q[$];
    localparam logic [7:0] CFG_A = {seq_pkg::CFG_IDX, 2'b00};
    localparam logic [7:0] CHN_A = {seq_pkg::CHAN_IDX, 2'b00};
    localparam logic [7:0] STK_A = {seq_pkg::STACK_IDX, 2'b00};
    localparam logic [7:0] STA_A = {seq_pkg::STAT_IDX, 2'b00};
    localparam logic [8:0] STK_V [3] = '{9'h052, 9'h0a7, 9'h13f};
    localparam int unsigned CC = seq_pkg::CONV_CYC;

    adc_channel_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sw_mode_strap(sw_mode_strap), .sequence_enable(sequence_enable),
        .burst_enable(burst_enable), .channel_range_select(channel_range_select),
        .conversion_start(conversion_start), .partial_reset(partial_reset), .busy(busy),
        .conv_launch(conv_launch), .conv_pair(conv_pair), .result_read(result_read),
        .result_pair(result_pair), .result_count(result_count));
    host_model host_u (.pclk(pclk), .busy(busy), .result_pair(result_pair),
        .conversion_start(conversion_start), .result_read(result_read), .frame_n(frame_n));

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Launch and busy monitor, sampled at the rising edge
    always @(posedge pclk) begin
        if (conv_launch === 1'b1) got_q.push_back(conv_pair);
        if (busy === 1'b1) busy_cyc++;
    end

    task check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task end_sim();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // Full reset with strap levels presented across the release
    task do_reset(input logic sw, input logic en, input logic bu, input logic [2:0] rng);
        @(posedge pclk);
        presetn              <= 1'b0;
        sw_mode_strap        <= sw;
        sequence_enable      <= en;
        burst_enable         <= bu;
        channel_range_select <= rng;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        got_q.delete();
        busy_cyc = 0;
    endtask : do_reset

    // One APB transfer; pready sampled at each edge of the access phase
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
             output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait limit here; only the watchdog ends a stuck access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check("prdata", exp, rd);
        check("pslverr", 32'(exp_err), 32'(err));
    endtask : rd_chk

    task run(input int n);
        repeat (n) begin
            host_u.start_conv();
            host_u.wait_idle();
        end
    endtask : run

    task expect_launch(input logic [7:0] e[$]);
        check("launches", 32'(e.size()), 32'(got_q.size()));
        foreach (e[i]) if (i < got_q.size()) check("conv_pair", 32'(e[i]), 32'(got_q[i]));
        got_q.delete();
    endtask : expect_launch

    task check_reads(input logic [7:0] e[$]);
        logic [7:0] p;
        check("result_count", 32'(e.size()), 32'(result_count));
        foreach (e[i]) begin
            host_u.read_one(p);
            check("result_pair", 32'(e[i]), 32'(p));
        end
        host_u.close_frame();
        repeat (2) @(posedge pclk);
        check("result_count drained", 32'h0000_0000, 32'(result_count));
    endtask : check_reads

    // Hardware sequence, range changed while idle before the final step of the first sequence
    task hw_sequence();
        do_reset(1'b0, 1'b1, 1'b0, 3'h3);
        run(3);
        @(posedge pclk);
        // new range held through final step
        channel_range_select <= 3'h1;
        sequence_enable      <= 1'b0;
        run(4);
        expect_launch('{8'h00, 8'h11, 8'h22, 8'h33, 8'h00, 8'h11, 8'h00});
        check("busy cycles", 32'(7 * CC), 32'(busy_cyc));
        do_reset(1'b0, 1'b0, 1'b0, 3'h7);
        run(2);
        expect_launch('{8'h00, 8'h00});
    endtask : hw_sequence

    // Hardware burst, with a start ignored mid-burst
    task hw_burst();
        do_reset(1'b0, 1'b1, 1'b1, 3'h2);
        host_u.start_conv();
        host_u.start_conv();
        host_u.wait_idle();
        expect_launch('{8'h00, 8'h11, 8'h22});
        check("burst busy", 32'(3 * CC), 32'(busy_cyc));
        check_reads('{8'h00, 8'h11, 8'h22});
        // new range set ahead of the next burst
        @(posedge pclk);
        channel_range_select <= 3'h1;
        run(1);
        expect_launch('{8'h00, 8'h11});
        do_reset(1'b0, 1'b0, 1'b1, 3'h2);
        run(1);
        expect_launch('{8'h00});
    endtask : hw_burst

    // Software stack: program, step, wrap, partial reset, burst
    task sw_stack();
        logic [31:0] rd;
        logic        err;
        do_reset(1'b1, 1'b0, 1'b0, 3'h0);
        rd_chk(CFG_A, 32'(seq_pkg::CFG_RST), 1'b0);
        rd_chk(STK_A + 8'h7c, 32'(seq_pkg::STACK_RST), 1'b0);
        for (int i = 0; i < 3; i++) wr(STK_A + 8'(4 * i), 32'(STK_V[i]));
        wr(STK_A + 8'h7c, 32'h0000_01ff);
        rd_chk(STK_A + 8'h7c, 32'h0000_01ff, 1'b0);
        wr(CFG_A, 32'h0000_0020);
        // unmapped write to address zero gets an error, then five starts
        apb(1'b1, 8'h00, 32'h0000_0000, rd, err);
        check("exit write err", 32'h0000_0001, 32'(err));
        run(5);
        expect_launch('{8'h52, 8'ha7, 8'h3f, 8'h52, 8'ha7});
        @(posedge pclk);
        partial_reset <= 1'b1;
        @(posedge pclk);
        partial_reset <= 1'b0;
        run(1);
        expect_launch('{8'h52});
        rd_chk(STK_A + 8'h04, 32'h0000_00a7, 1'b0);
        rd_chk(CFG_A, 32'h0000_0020, 1'b0);
        rd_chk(8'h04, 32'h0000_0000, 1'b1);
        // partial reset aborts a step under way
        host_u.start_conv();
        @(posedge pclk);
        partial_reset <= 1'b1;
        @(posedge pclk);
        partial_reset <= 1'b0;
        @(posedge pclk);
        check("busy after partial reset", 32'h0000_0000, 32'(busy));
        expect_launch('{8'ha7});
        wr(CFG_A, 32'h0000_0060);
        busy_cyc = 0;
        run(1);
        expect_launch('{8'h52, 8'ha7, 8'h3f});
        check("sw burst busy", 32'(3 * CC), 32'(busy_cyc));
        check_reads('{8'h52, 8'ha7, 8'h3f});
        rd_chk(STA_A, 32'h0000_0380, 1'b0);
        wr(CFG_A, 32'h0000_0040);
        rd_chk(STA_A, 32'h0000_0080, 1'b0);
        wr(CHN_A, 32'h0000_00c4);
        run(1);
        expect_launch('{8'hc4});
    endtask : sw_stack

    // Main sequence
    initial begin
        error_cnt = 0;
        checks = 0;
        busy_cyc = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sw_mode_strap = 1'b0;
        sequence_enable = 1'b0;
        burst_enable = 1'b0;
        channel_range_select = 3'h0;
        partial_reset = 1'b0;
        hw_sequence();
        hw_burst();
        sw_stack();
        end_sim();
    end

    // Watchdog well beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end
endmodule : test_adc_channel_sequencer
